// ### serial_flash_sector_protect_tb_top.sv
// self-checking bench joining host and device ends
`timescale 1ns/100ps
module serial_flash_sector_protect_tb_top;
  import ssp_pkg::*;
  localparam int ERASE = 20;
  localparam int WPC   = 8;
  logic                mclk = 1'b0, reset = 1'b1, ce = 1'b1;
  logic                cmd_valid = 1'b0, wp_assert = 1'b0, op_valid = 1'b0;
  ssp_cmd_e            cmd_sel = SSP_CMD_ENABLE;
  logic [SECTOR_W-1:0] op_sector = 6'h00;
  logic [PAGE_W-1:0]   op_page = 7'h00;
  logic                cmd_ready_q, op_grant_q, op_deny_q, prot_enabled_q;
  logic                map_busy_q, sw_enabled_q, wp_active_q, sw2_q;
  logic                map_ff = 1'b0; // map contents: all 00 or all FF
  int                  errors = 0, checks_done = 0, seed = 26;
  ssp_link_if link ();
  ssp_link_if link2 ();
  always #5 mclk = ~mclk;
  ssp_host ssp_host_i (.mclk(mclk), .reset(reset), .ce(ce), .link(link.host), .cmd_valid(cmd_valid),
    .cmd_sel(cmd_sel), .wp_assert(wp_assert), .cmd_ready_q(cmd_ready_q));
  ssp_device #(.ERASE_CYCLES(ERASE), .WPE_CYCLES(WPC), .WPD_CYCLES(WPC)) ssp_device_i (.mclk(mclk),
    .reset(reset), .ce(ce), .link(link.dev), .op_valid(op_valid), .op_sector(op_sector), .op_page(op_page),
    .op_grant_q(op_grant_q), .op_deny_q(op_deny_q), .prot_enabled_q(prot_enabled_q), .map_busy_q(map_busy_q),
    .sw_enabled_q(sw_enabled_q), .wp_active_q(wp_active_q));
  // second device, its link driven by the bench to check that a command commits only on chip select release
  ssp_device #(.ERASE_CYCLES(ERASE), .WPE_CYCLES(WPC), .WPD_CYCLES(WPC)) ssp_device_i2 (.mclk(mclk),
    .reset(reset), .ce(ce), .link(link2.dev), .op_valid(op_valid), .op_sector(op_sector), .op_page(op_page),
    .op_grant_q(), .op_deny_q(), .prot_enabled_q(), .map_busy_q(), .sw_enabled_q(sw2_q), .wp_active_q());
  ssp_link_monitor #(.ERASE_CYCLES(ERASE), .WPE_CYCLES(WPC), .WPD_CYCLES(WPC)) ssp_link_monitor_i (
    .mclk(mclk), .reset(reset), .ce(ce), .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi), .wp_n(link.wp_n),
    .op_valid(op_valid), .op_grant_q(op_grant_q), .op_deny_q(op_deny_q), .prot_enabled_q(prot_enabled_q),
    .map_busy_q(map_busy_q), .sw_enabled_q(sw_enabled_q), .wp_active_q(wp_active_q));

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %b seen %b", name, exp, seen);
    end
  endtask
  // inputs change 1 ns after the edge so the design samples settled values
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  function automatic logic deny_exp(input logic prot, input logic busy);
    return busy | (prot & map_ff);
  endfunction
  task automatic req(input logic [SECTOR_W-1:0] s, input logic [PAGE_W-1:0] p, input logic prot, input logic busy);
    op_valid = 1'b1;
    op_sector = s;
    op_page = p;
    tick(1);
    op_valid = 1'b0;
    check("op_deny_q", op_deny_q, deny_exp(prot, busy));
    check("op_grant_q", op_grant_q, !deny_exp(prot, busy));
    tick(1);
  endtask
  // sector 0 both halves and the top sector first, then random targets
  task automatic burst(input logic prot);
    req(6'h00, 7'h07, prot, 1'b0);
    req(6'h00, SUB0B_FIRST_PG, prot, 1'b0);
    req(6'h3F, 7'h7F, prot, 1'b0);
    repeat (5) req(SECTOR_W'($random(seed)), PAGE_W'($random(seed)), prot, 1'b0);
  endtask
  task automatic wait_ready;
    for (int n = 0; n < 1000 && cmd_ready_q !== 1'b1; n++) tick(1);
    check("cmd_ready_q", cmd_ready_q, 1'b1);
  endtask
  task automatic send(input ssp_cmd_e c);
    wait_ready;
    cmd_valid = 1'b1;
    cmd_sel = c;
    tick(1);
    cmd_valid = 1'b0;
    check("cmd_ready_q", cmd_ready_q, 1'b0);
    wait_ready;
    tick(6);
  endtask
  task automatic wp(input logic a);
    wp_assert = a;
    tick(WPC + 8);
  endtask
  task automatic status(input string t, input logic sw, input logic prot);
    check("sw_enabled_q", sw_enabled_q, sw);
    check("prot_enabled_q", prot_enabled_q, prot);
    $display("test %s done", t);
  endtask
  // link clock of 125 ns, free of any phase tie to mclk
  task automatic bang(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      link2.mosi = w[i];
      #31 link2.sck = 1'b1;
      #62.5 link2.sck = 1'b0;
      #31.5;
    end
  endtask

  // watchdog: the tests take about 4.5k cycles, allow 80k cycles, over sixteen times that
  initial
  begin
    #800000;
    errors++;
    complete_run;
  end
  initial
  begin
    link2.cs_n = 1'b1;
    link2.sck = 1'b0;
    link2.mosi = 1'b0;
    link2.wp_n = 1'b1;
    tick(20);
    reset = 1'b0;
    tick(4);
    check("map_busy_q", map_busy_q, 1'b0);
    status("reset", 1'b0, 1'b0);
    burst(1'b0);
    send(SSP_CMD_ENABLE);
    status("enable", 1'b1, 1'b1);
    burst(1'b1);
    send(SSP_CMD_ERASE);
    check("map_busy_q", map_busy_q, 1'b1);
    // clock enable low must freeze the erase timer
    ce = 1'b0;
    tick(ERASE + 4);
    check("map_busy_q", map_busy_q, 1'b1);
    ce = 1'b1;
    req(SECTOR_W'($random(seed)), 7'h00, 1'b1, 1'b1);
    tick(ERASE + 4);
    map_ff = 1'b1;
    check("map_busy_q", map_busy_q, 1'b0);
    burst(1'b1);
    send(SSP_CMD_DISABLE);
    status("disable", 1'b0, 1'b0);
    burst(1'b0);
    wp(1'b1);
    check("wp_active_q", wp_active_q, 1'b1);
    burst(1'b1);
    send(SSP_CMD_ERASE);
    check("map_busy_q", map_busy_q, 1'b0);
    send(SSP_CMD_ENABLE);
    send(SSP_CMD_DISABLE);
    status("wp disable", 1'b1, 1'b1);
    wp(1'b0);
    status("wp release", 1'b1, 1'b1);
    send(SSP_CMD_DISABLE);
    wp(1'b1);
    status("wp only", 1'b0, 1'b1);
    wp(1'b0);
    status("wp lapse", 1'b0, 1'b0);
    wp_assert = 1'b1;
    tick(2);
    wp_assert = 1'b0;
    tick(2);
    check("wp_active_q", wp_active_q, 1'b0);
    send(SSP_CMD_ENABLE);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(4);
    map_ff = 1'b0;
    status("second reset", 1'b0, 1'b0);
    burst(1'b0);
    send(SSP_CMD_ENABLE);
    status("re-enable", 1'b1, 1'b1);
    burst(1'b1);
    link2.cs_n = 1'b0;
    bang({CMD_PREFIX0, CMD_PREFIX1, CMD_PREFIX2, OP_ENABLE});
    #500;
    check("sw2_q", sw2_q, 1'b0);
    link2.cs_n = 1'b1;
    link2.mosi = ~link2.mosi;
    tick(8);
    check("sw2_q", sw2_q, 1'b1);
    status("commit on cs", 1'b1, 1'b1);
    complete_run;
  end
endmodule

// ### ssp_device.sv
// flash sector protection logic: command decode, protection map, map erase
//
// Behaviour
// RQ1: reset clears software protection enable
// RQ2: 3D 2A 7F A9 sets protection enable
// RQ3: host raises chip select to commit command
// RQ4: 3D 2A 7F 9A clears protection enable
// RQ5: asserted wp guards marked sectors and map
// RQ6: host releases wp before map erase
// RQ7: wp alone enables protection within delay
// RQ8: enable issued under wp survives wp release
// RQ9: disable ignored while wp asserted
// RQ10: wp never changes the software enable flag
// RQ11: wp input filtered against glitches
// RQ12: map holds 64 bytes, one per sector
// RQ13: sectors 1-63: FF protected, 00 not
// RQ14: byte 0 bits 7:6 guard 0a, 5:4 0b
// RQ15: map bytes start at 00
// RQ16: host erases map before reprogramming
// RQ17: 3D 2A 7F CF starts timed map erase
// RQ18: busy shown during map erase
// RQ19: erase sets all map bytes FF
// RQ20: erased map plus enable blocks everything
// RQ21: without wp host re-enables after power-up
// RQ22: status shows protection enabled
// RQ23: protected target request discarded untouched
// RQ24: active protection is enable flag or wp
`timescale 1ns/100ps
module ssp_device
  import ssp_pkg::*;
#(
  parameter int ERASE_CYCLES = MAP_ERASE_CYCLES,
  parameter int WPE_CYCLES   = WP_ASSERT_CYCLES,
  parameter int WPD_CYCLES   = WP_RELEASE_CYCLES
)(
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                ce,
  ssp_link_if.dev                  link,
  input  wire logic                op_valid,
  input  wire logic [SECTOR_W-1:0] op_sector,
  input  wire logic [PAGE_W-1:0]   op_page,
  output logic                     op_grant_q,
  output logic                     op_deny_q,
  output logic                     prot_enabled_q,
  output logic                     map_busy_q,
  output logic                     sw_enabled_q,
  output logic                     wp_active_q
);

  typedef struct packed {
    logic [1:0]             sck_s;
    logic [1:0]             cs_s;
    logic [1:0]             mosi_s;
    logic                   sck_prev;
    logic                   cs_prev;
    logic [7:0]             shift;
    logic [2:0]             bitc;
    logic [2:0]             bytec;
    logic                   match;
    logic [7:0]             opcode;
    logic                   sw_en;
    logic                   prot;
    logic                   busy;
    logic [31:0]            erase_cnt;
    logic [MAP_BYTES*8-1:0] map;
    logic                   grant;
    logic                   deny;
  } ssp_dev_s;

  ssp_dev_s             q;
  ssp_dev_s             d;
  logic                 wp_active;
  logic                 sck_rise;
  logic                 cs_rise;
  logic                 cmd_ok;
  logic [7:0]           next_byte;
  logic [MAP_BYTES-1:0] sec_marked;
  logic                 sub0b_marked;
  logic                 target_marked;
  logic                 prot_active;

  // write-protect pin passes sync and filter before anything sees it
  ssp_wp_filter #(
    .ASSERT_CYCLES  (WPE_CYCLES - SYNC_STAGES - 1),
    .RELEASE_CYCLES (WPD_CYCLES - SYNC_STAGES - 1)
  ) u_wp_filter (
    .mclk        (mclk),
    .reset       (reset),
    .ce          (ce),
    .wp_n_pin    (link.wp_n),
    .wp_active_q (wp_active)
  );

  // link edges, seen only after the second sync stage
  assign sck_rise  = q.sck_s[1] & ~q.sck_prev;
  assign cs_rise   = q.cs_s[1] & ~q.cs_prev;
  assign next_byte = {q.shift[6:0], q.mosi_s[1]};
  // a whole four-byte sequence, no stray bits, with a good prefix
  assign cmd_ok    = q.match && (q.bytec == CMD_BYTES) && (q.bitc == 3'h0); // RQ3

  // per-sector map decode; entry 0 carries the 0a half in its top bits
  for (genvar n = 0; n < MAP_BYTES; n++)
  begin : g_marked
    if (n == 0)
    begin : g_sec0
      assign sec_marked[n] = q.map[SUB0A_HI -: 2] == SUB_PROTECTED; // RQ14
    end
    else
    begin : g_secn
      assign sec_marked[n] = q.map[n*8 +: 8] == MAP_PROTECTED; // RQ12 RQ13
    end
  end

  // low nibble of entry 0 is never looked at
  assign sub0b_marked  = q.map[SUB0B_HI -: 2] == SUB_PROTECTED; // RQ14

  // pages 0-7 belong to 0a, the rest of sector 0 to 0b
  assign target_marked = (op_sector == '0 && op_page >= SUB0B_FIRST_PG) ? sub0b_marked
                                                                        : sec_marked[op_sector];

  // software flag or filtered pin; the pin also blocks the disable and erase commands
  assign prot_active   = q.sw_en | wp_active; // RQ24 RQ10 RQ7

  // command shifter, command actions, timed erase and request check
  always_comb
  begin
    d          = q;
    d.sck_s    = {q.sck_s[0], link.sck};
    d.cs_s     = {q.cs_s[0], link.cs_n};
    d.mosi_s   = {q.mosi_s[0], link.mosi};
    d.sck_prev = q.sck_s[1];
    d.cs_prev  = q.cs_s[1];
    d.grant    = 1'b0;
    d.deny     = 1'b0;

    // frame framing: chip select high parks the shifter
    if (q.cs_s[1])
    begin
      d.bitc  = 3'h0;
      d.bytec = 3'h0;
      d.match = 1'b1;
    end
    else if (sck_rise)
    begin
      d.shift = next_byte;
      d.bitc  = q.bitc + 3'h1;
      if (q.bitc == 3'h7)
      begin
        // count saturates past four so longer frames never match
        if (q.bytec <= CMD_BYTES)
        begin
          d.bytec = q.bytec + 3'h1;
        end
        if (q.bytec == 3'h0 && next_byte != CMD_PREFIX0)
        begin
          d.match = 1'b0;
        end
        if (q.bytec == 3'h1 && next_byte != CMD_PREFIX1)
        begin
          d.match = 1'b0;
        end
        if (q.bytec == 3'h2 && next_byte != CMD_PREFIX2)
        begin
          d.match = 1'b0;
        end
        if (q.bytec == 3'h3)
        begin
          d.opcode = next_byte;
        end
      end
    end

    // commands act only on the chip select release, never mid-frame
    if (cs_rise && cmd_ok && !q.busy)
    begin
      if (q.opcode == OP_ENABLE)
      begin
        d.sw_en = 1'b1; // RQ2 RQ8
      end
      else if (q.opcode == OP_DISABLE && !wp_active)
      begin
        d.sw_en = 1'b0; // RQ4 RQ9
      end
      else if (q.opcode == OP_ERASE && !wp_active)
      begin
        // accepted whatever the enable state; refused under wp
        d.busy      = 1'b1; // RQ17 RQ5 RQ19
        d.erase_cnt = 32'h0000_0000;
      end
    end

    // self-timed erase; map flips to all-protected at the end
    if (q.busy)
    begin
      if (q.erase_cnt == 32'(ERASE_CYCLES - 1))
      begin
        d.map  = {MAP_BYTES{MAP_PROTECTED}}; // RQ19 RQ20
        d.busy = 1'b0; // RQ18
      end
      else
      begin
        d.erase_cnt = q.erase_cnt + 32'h0000_0001;
      end
    end

    // program/erase request gate; denied requests change nothing
    if (op_valid)
    begin
      if (q.busy || (prot_active && target_marked))
      begin
        d.deny = 1'b1; // RQ23 RQ5 RQ20
      end
      else
      begin
        d.grant = 1'b1;
      end
    end

    d.prot = d.sw_en | wp_active; // RQ22
  end

  // power cycle: software enable off, map at its delivered value
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q         <= '0;
      q.cs_s    <= 2'h3;
      q.cs_prev <= 1'b1;
      q.match   <= 1'b1;
      q.sw_en   <= 1'b0; // RQ1
      q.map     <= {MAP_BYTES{MAP_RESET_BYTE}}; // RQ15
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // all outputs straight from state flops
  assign op_grant_q     = q.grant;
  assign op_deny_q      = q.deny;
  assign prot_enabled_q = q.prot;
  assign map_busy_q     = q.busy; // RQ18
  assign sw_enabled_q   = q.sw_en;
  assign wp_active_q    = wp_active;

endmodule

// ### ssp_host.sv
// host end: sends protection command sequences and drives write-protect
`timescale 1ns/100ps
module ssp_host
  import ssp_pkg::*;
#(
  parameter int HALF_CYCLES = SCK_HALF_CYCLES
)(
  input  wire logic     mclk,
  input  wire logic     reset,
  input  wire logic     ce,
  ssp_link_if.host      link,
  input  wire logic     cmd_valid,
  input  wire ssp_cmd_e cmd_sel,
  input  wire logic     wp_assert,
  output logic          cmd_ready_q
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10,
    ST_GAP  = 2'b11
  } ssp_host_e;

  typedef struct packed {
    ssp_host_e   st;
    logic [15:0] cnt;
    logic [5:0]  bits;
    logic [31:0] word;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic        wp_n;
    logic        ready;
  } ssp_host_s;

  ssp_host_s  q;
  ssp_host_s  d;
  logic       half_done;
  logic [7:0] opcode;

  assign half_done = q.cnt == 16'(HALF_CYCLES - 1);

  always_comb
  begin
    unique case (cmd_sel)
      SSP_CMD_ENABLE:  opcode = OP_ENABLE;
      SSP_CMD_DISABLE: opcode = OP_DISABLE;
      SSP_CMD_ERASE:   opcode = OP_ERASE;
      default:         opcode = OP_ENABLE;
    endcase
  end

  // mode 0 shifter: data moves on sck fall, device samples on rise
  always_comb
  begin
    d      = q;
    d.wp_n = ~wp_assert; // RQ6
    d.cnt  = half_done ? 16'h0000 : q.cnt + 16'h0001;
    unique case (q.st)
      ST_IDLE:
      begin
        d.cnt = 16'h0000;
        if (cmd_valid)
        begin
          d.word  = {CMD_PREFIX0, CMD_PREFIX1, CMD_PREFIX2, opcode};
          d.mosi  = CMD_PREFIX0[7];
          d.cs_n  = 1'b0;
          d.bits  = 6'h00;
          d.ready = 1'b0;
          d.st    = ST_LOW;
        end
      end
      ST_LOW:
      begin
        if (half_done)
        begin
          d.sck = 1'b1;
          d.st  = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (half_done)
        begin
          d.sck  = 1'b0;
          d.word = {q.word[30:0], 1'b0};
          d.mosi = q.word[30];
          d.bits = q.bits + 6'h01;
          d.st   = (q.bits == 6'(CMD_BITS - 1)) ? ST_GAP : ST_LOW;
        end
      end
      ST_GAP:
      begin
        // release chip select a half period after the last bit, then idle
        if (half_done)
        begin
          if (!q.cs_n)
          begin
            d.cs_n = 1'b1; // RQ3
          end
          else
          begin
            d.ready = 1'b1;
            d.st    = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.cs_n  <= 1'b1;
      q.wp_n  <= 1'b1;
      q.ready <= 1'b1;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign link.sck    = q.sck;
  assign link.cs_n   = q.cs_n;
  assign link.mosi   = q.mosi;
  assign link.wp_n   = q.wp_n;
  assign cmd_ready_q = q.ready;

endmodule

// ### ssp_link_if.sv
// serial command link between host controller and flash protection logic
`timescale 1ns/100ps
interface ssp_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic wp_n;

  modport host (output sck, output cs_n, output mosi, output wp_n);
  modport dev  (input sck, input cs_n, input mosi, input wp_n);
endinterface

// ### ssp_link_monitor.sv
// checker for the protection link and the device status outputs
`timescale 1ns/100ps
module ssp_link_monitor
  import ssp_pkg::*;
#(
  parameter int ERASE_CYCLES = 20,
  parameter int WPE_CYCLES   = 8,
  parameter int WPD_CYCLES   = 8
)(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  input wire logic op_valid,
  input wire logic op_grant_q,
  input wire logic op_deny_q,
  input wire logic prot_enabled_q,
  input wire logic map_busy_q,
  input wire logic sw_enabled_q,
  input wire logic wp_active_q
);
  logic [7:0] busy_n_q;
  logic [7:0] low_n_q;
  logic [7:0] high_n_q;
  // run lengths; the wp counters saturate so a long wp level cannot wrap
  always_ff @(posedge mclk)
  begin
    busy_n_q <= (reset || !map_busy_q) ? 8'h00 : busy_n_q + {7'h00, ce}; // erase timer frozen while ce low
    low_n_q  <= (reset || wp_n) ? 8'h00 : low_n_q + {7'h00, low_n_q != 8'h40};
    high_n_q <= (reset || !wp_n) ? 8'h00 : high_n_q + {7'h00, high_n_q != 8'h40};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_reset_idle; disable iff (1'b0) reset |=> cs_n && wp_n && !sck && !sw_enabled_q && !map_busy_q; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("state not idle after reset");
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck active outside a frame");
  property p_commit; $rose(sw_enabled_q) |-> cs_n && $past(cs_n, 3); endproperty
  a_commit: assert property (p_commit) else $error("enable took effect before chip select rose");
  property p_disable_wp; $fell(sw_enabled_q) |-> !$past(wp_active_q); endproperty
  a_disable_wp: assert property (p_disable_wp) else $error("disable accepted under write protect");
  property p_prot_on; (sw_enabled_q || wp_active_q) |-> ##[0:1] prot_enabled_q; endproperty
  a_prot_on: assert property (p_prot_on) else $error("protection not enabled");
  property p_prot_off; !(sw_enabled_q || wp_active_q) && !$past(sw_enabled_q || wp_active_q) |-> !prot_enabled_q; endproperty
  a_prot_off: assert property (p_prot_off) else $error("protection enabled without cause");
  property p_answer; op_valid |=> op_grant_q != op_deny_q; endproperty
  a_answer: assert property (p_answer) else $error("request without exactly one answer");
  property p_quiet; !op_valid |=> !op_grant_q && !op_deny_q; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_busy_deny; op_valid && map_busy_q |=> op_deny_q; endproperty
  a_busy_deny: assert property (p_busy_deny) else $error("request granted during map erase");
  property p_erase_len; $fell(map_busy_q) |-> busy_n_q >= ERASE_CYCLES - 1 && busy_n_q <= ERASE_CYCLES + 1; endproperty
  a_erase_len: assert property (p_erase_len) else $error("map erase length wrong");
  property p_wp_glitch; $rose(wp_active_q) |-> low_n_q >= WPE_CYCLES - 4; endproperty
  a_wp_glitch: assert property (p_wp_glitch) else $error("short wp pulse took effect");
  property p_wp_on; low_n_q >= WPE_CYCLES + 4 |-> wp_active_q; endproperty
  a_wp_on: assert property (p_wp_on) else $error("wp assertion too slow");
  property p_wp_off; high_n_q >= WPD_CYCLES + 4 |-> !wp_active_q; endproperty
  a_wp_off: assert property (p_wp_off) else $error("wp release too slow");
endmodule

// ### ssp_pkg.sv
// shared constants and types for the sector protection link
package ssp_pkg;

  // mclk period and link timing
  localparam int CLK_PERIOD_NS               = 10;
  localparam int WP_ASSERT_PROTECT_DELAY_NS  = 1000;
  localparam int WP_RELEASE_PROTECT_DELAY_NS = 1000;
  localparam int MAP_ERASE_TIME_MAX_NS       = 50000;
  localparam int SYNC_STAGES                 = 2;
  // longest times round down to whole cycles
  localparam int WP_ASSERT_CYCLES  = WP_ASSERT_PROTECT_DELAY_NS / CLK_PERIOD_NS;
  localparam int WP_RELEASE_CYCLES = WP_RELEASE_PROTECT_DELAY_NS / CLK_PERIOD_NS;
  localparam int MAP_ERASE_CYCLES  = MAP_ERASE_TIME_MAX_NS / CLK_PERIOD_NS;
  // host sck half period in mclk cycles (60 ns)
  localparam int SCK_HALF_CYCLES   = 6;

  // four-byte command sequences
  localparam logic [7:0] CMD_PREFIX0 = 8'h3D;
  localparam logic [7:0] CMD_PREFIX1 = 8'h2A;
  localparam logic [7:0] CMD_PREFIX2 = 8'h7F;
  localparam logic [7:0] OP_ENABLE   = 8'hA9;
  localparam logic [7:0] OP_DISABLE  = 8'h9A;
  localparam logic [7:0] OP_ERASE    = 8'hCF;
  localparam logic [2:0] CMD_BYTES   = 3'h4;
  localparam int         CMD_BITS    = 32;

  // protection map layout
  localparam int         MAP_BYTES      = 64;
  localparam int         SECTOR_W       = 6;
  localparam int         PAGE_W         = 7;
  localparam logic [7:0] MAP_PROTECTED  = 8'hFF;
  localparam logic [7:0] MAP_RESET_BYTE = 8'h00;
  localparam logic [1:0] SUB_PROTECTED  = 2'h3;
  localparam int         SUB0A_HI       = 7;
  localparam int         SUB0B_HI       = 5;
  localparam logic [6:0] SUB0B_FIRST_PG = 7'h08;

  // host command selector
  typedef enum logic [1:0] {
    SSP_CMD_ENABLE  = 2'b00,
    SSP_CMD_DISABLE = 2'b01,
    SSP_CMD_ERASE   = 2'b10
  } ssp_cmd_e;

endpackage

// ### ssp_wp_filter.sv
// write-protect pin synchroniser and noise filter
`timescale 1ns/100ps
module ssp_wp_filter
  import ssp_pkg::*;
#(
  parameter int ASSERT_CYCLES  = 8,
  parameter int RELEASE_CYCLES = 8
)(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic wp_n_pin,
  output logic      wp_active_q
);

  typedef struct packed {
    logic [1:0]  sync;
    logic        active;
    logic [15:0] cnt;
  } ssp_filt_s;

  ssp_filt_s q;
  ssp_filt_s d;
  logic      lvl;

  // pin is active low; only the second stage is looked at
  assign lvl = ~q.sync[1];

  // new level must hold for the full count, so glitches never toggle protection
  always_comb
  begin
    d = q;
    d.sync = {q.sync[0], wp_n_pin};
    if (lvl == q.active)
    begin
      d.cnt = 16'h0000;
    end
    else if (q.cnt == (q.active ? 16'(RELEASE_CYCLES - 1) : 16'(ASSERT_CYCLES - 1)))
    begin
      d.active = lvl; // RQ11
      d.cnt    = 16'h0000;
    end
    else
    begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q        <= '0;
      q.sync   <= 2'h3; // pin idles pulled high
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign wp_active_q = q.active;

endmodule
